/* design/fsc_pkg.sv */
// package: constants for the flash status controller
package fsc_pkg;
  // ---------------------------------------------------------------
  // register offsets (apb byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_RDATA  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CFG    = 8'h14;
  // ---------------------------------------------------------------
  // ctrl command codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CMD_NONE  = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h1;
  localparam logic [2:0] CMD_READ  = 3'h2;
  localparam logic [2:0] CMD_POLL  = 3'h3;
  localparam logic [2:0] CMD_RESET = 3'h4;
  localparam logic [2:0] CMD_ERCHK = 3'h5;
  // ---------------------------------------------------------------
  // status bit positions
  // ---------------------------------------------------------------
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_FAIL    = 2;
  localparam int ST_RDY     = 3;
  localparam int ST_NOTACC  = 4;
  localparam int ST_RSTDONE = 5;
  // ---------------------------------------------------------------
  // flash data bit positions
  // ---------------------------------------------------------------
  localparam int FL_OP_TOGGLE = 6;
  localparam int FL_TIMEOUT   = 5;
  localparam int FL_ERWINDOW  = 3;
  // ---------------------------------------------------------------
  // timing (cycles at 50 MHz)
  // ---------------------------------------------------------------
  localparam int CLK_NS       = 20;
  localparam int T_PHASE_NS   = 100;
  localparam int T_PHASE_CYC  = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RESET_NS   = 500;
  localparam int T_RESET_CYC  = (T_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] RESET_CMD = 8'hf0;
  localparam logic [31:0] CFG_RESET = 32'h0000_0001;
endpackage

/* design/fsc_bus_if.sv */
// interface: pin-cycle request between sequencer and pin engine
`timescale 1ns/1ps
interface fsc_bus_if;
  logic        req;
  logic        wr;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic        word_mode;
  logic        ack;
  logic [15:0] rdata;
  modport master (output req, output wr, output addr, output wdata, output word_mode,
                  input ack, input rdata);
  modport slave  (input req, input wr, input addr, input wdata, input word_mode,
                  output ack, output rdata);
endinterface

/* design/fsc_pin_engine.sv */
// module: one flash bus cycle on the device pins
`timescale 1ns/1ps
module fsc_pin_engine (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // request
  fsc_bus_if.slave  bus,
  // flash pins
  output logic        ce_n,
  output logic        oe_n,
  output logic        we_n,
  output logic [18:0] fl_addr,
  output logic [15:0] dq_o,
  output logic        dq_oe_n,
  output logic        top_data_or_low_addr_o,
  output logic        top_data_or_low_addr_oe_n,
  input  wire logic [15:0] dq_i
);
  typedef enum logic [1:0] {PE_IDLE, PE_ACT, PE_HOLD, PE_DONE} fsc_pe_t;
  fsc_pe_t    state_reg;
  logic [3:0] cnt_reg;
  logic [15:0] s1_reg;
  logic [15:0] s2_reg;

  // ---------------------------------------------------------------
  // input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    s1_reg <= dq_i;
    s2_reg <= s1_reg;
  end

  // ---------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= PE_IDLE;
      cnt_reg   <= 4'h0;
      ce_n      <= 1'b1;
      oe_n      <= 1'b1;
      we_n      <= 1'b1;
      dq_oe_n   <= 1'b1;
      top_data_or_low_addr_oe_n <= 1'b1;
      top_data_or_low_addr_o    <= 1'b0;
      fl_addr   <= 19'h0;
      dq_o      <= 16'h0;
      bus.ack   <= 1'b0;
      bus.rdata <= 16'h0;
    end else begin
      bus.ack <= 1'b0;
      unique case (state_reg)
        PE_IDLE: begin
          if (bus.req) begin
            // word mode uses all lines, byte mode turns top line into low address
            fl_addr <= bus.word_mode ? bus.addr[18:0] : bus.addr[19:1];
            top_data_or_low_addr_o    <= bus.word_mode ? bus.wdata[15] : bus.addr[0];
            top_data_or_low_addr_oe_n <= bus.word_mode ? ~bus.wr : 1'b0;
            dq_o     <= {1'b0, (bus.word_mode ? bus.wdata[14:8] : 7'h0), bus.wdata[7:0]};
            dq_oe_n  <= ~bus.wr;
            ce_n     <= 1'b0;
            // write needs oe high with ce and we low; reads never lower we
            oe_n     <= bus.wr;
            we_n     <= ~bus.wr;
            cnt_reg  <= 4'h0;
            state_reg <= PE_ACT;
          end
        end
        PE_ACT: begin
          cnt_reg <= cnt_reg + 4'h1;
          // we rises a cycle before ce so the write edge sees ce low
          if (cnt_reg == 4'(fsc_pkg::T_PHASE_CYC + 1)) begin
            we_n <= 1'b1;
          end
          if (cnt_reg == 4'(fsc_pkg::T_PHASE_CYC + 2)) begin
            bus.rdata <= bus.word_mode ? s2_reg : {8'h0, s2_reg[7:0]};
            // deassert ce and oe between reads so each read is delimited
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            cnt_reg   <= 4'h0;
            state_reg <= PE_HOLD;
          end
        end
        PE_HOLD: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'(fsc_pkg::T_PHASE_CYC)) begin
            dq_oe_n <= 1'b1;
            top_data_or_low_addr_oe_n <= 1'b1;
            bus.ack   <= 1'b1;
            state_reg <= PE_DONE;
          end
        end
        PE_DONE: state_reg <= PE_IDLE;
      endcase
    end
  end
endmodule

/* design/fsc_top.sv */
// module: apb-controlled host sequencer for a parallel nor flash
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
module fsc_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // flash pins
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             flash_reset_n,
  output logic             byte_word_sel,
  output logic [18:0]      fl_addr,
  output logic [15:0]      dq_o,
  output logic             dq_oe_n,
  output logic             top_data_or_low_addr_o,
  output logic             top_data_or_low_addr_oe_n,
  input  wire logic [15:0] dq_i,
  input  wire logic        ready_busy_n_in
);
  typedef enum logic [2:0] {SQ_IDLE, SQ_CYCLE, SQ_POLL2, SQ_POLL3, SQ_RESET, SQ_ERCHK} fsc_sq_t;

  fsc_bus_if bus ();
  fsc_sq_t     state_reg;
  logic [31:0] cfg_reg;
  logic [19:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [15:0] first_reg;
  logic [5:0]  status_reg;
  logic        rb_s1_reg;
  logic        rb_s2_reg;
  logic [7:0]  rst_cnt_reg;
  logic        wr_reg;
  logic        after_reset_reg;
  logic        apb_wr;

  assign apb_wr = psel && penable && pwrite && pready;

  fsc_pin_engine u_pins (
    .mclk                      (mclk),
    .reset                     (reset),
    .bus                       (bus.slave),
    .ce_n                      (ce_n),
    .oe_n                      (oe_n),
    .we_n                      (we_n),
    .fl_addr                   (fl_addr),
    .dq_o                      (dq_o),
    .dq_oe_n                   (dq_oe_n),
    .top_data_or_low_addr_o    (top_data_or_low_addr_o),
    .top_data_or_low_addr_oe_n (top_data_or_low_addr_oe_n),
    .dq_i                      (dq_i)
  );

  assign bus.addr      = addr_reg;
  assign bus.wdata     = wdata_reg;
  assign bus.wr        = wr_reg;
  assign bus.word_mode = cfg_reg[0];

  // ---------------------------------------------------------------
  // ready/busy synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    rb_s1_reg <= ready_busy_n_in;
    rb_s2_reg <= rb_s1_reg;
  end

  // ---------------------------------------------------------------
  // apb answer, one wait-free access phase
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        unique case (paddr)
          fsc_pkg::OFS_CTRL:   prdata <= 32'h0;
          fsc_pkg::OFS_ADDR:   prdata <= {12'h0, addr_reg};
          fsc_pkg::OFS_WDATA:  prdata <= {16'h0, wdata_reg};
          fsc_pkg::OFS_RDATA:  prdata <= {16'h0, rdata_reg};
          fsc_pkg::OFS_STATUS: prdata <= {26'h0, status_reg[5:4], rb_s2_reg, status_reg[2:1], status_reg[0]};
          fsc_pkg::OFS_CFG:    prdata <= cfg_reg;
          default: begin
            prdata  <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration and operand registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_reg   <= fsc_pkg::CFG_RESET;
      addr_reg  <= 20'h0;
      wdata_reg <= 16'h0;
      byte_word_sel <= 1'b1;
    end else begin
      byte_word_sel <= cfg_reg[0];
      if (apb_wr && paddr == fsc_pkg::OFS_CFG) cfg_reg <= {31'h0, pwdata[0]};
      if (apb_wr && paddr == fsc_pkg::OFS_ADDR) addr_reg <= pwdata[19:0];
      if (apb_wr && paddr == fsc_pkg::OFS_WDATA) wdata_reg <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg   <= SQ_IDLE;
      bus.req     <= 1'b0;
      wr_reg      <= 1'b0;
      rdata_reg   <= 16'h0;
      first_reg   <= 16'h0;
      status_reg  <= 6'h0;
      rst_cnt_reg <= 8'h0;
      after_reset_reg <= 1'b0;
      flash_reset_n <= 1'b1;
    end else begin
      bus.req <= 1'b0;
      unique case (state_reg)
        SQ_IDLE: begin
          if (apb_wr && paddr == fsc_pkg::OFS_CTRL) begin
            status_reg[fsc_pkg::ST_BUSY] <= 1'b1;
            status_reg[fsc_pkg::ST_DONE] <= 1'b0;
            status_reg[fsc_pkg::ST_RSTDONE] <= 1'b0;
            unique case (pwdata[2:0])
              fsc_pkg::CMD_WRITE, fsc_pkg::CMD_READ: begin
                wr_reg    <= (pwdata[2:0] == fsc_pkg::CMD_WRITE);
                bus.req   <= 1'b1;
                state_reg <= SQ_CYCLE;
              end
              fsc_pkg::CMD_POLL: begin
                status_reg[fsc_pkg::ST_FAIL] <= 1'b0;
                wr_reg    <= 1'b0;
                bus.req   <= 1'b1;
                after_reset_reg <= 1'b0;
                state_reg <= SQ_POLL2;
              end
              fsc_pkg::CMD_RESET: begin
                flash_reset_n <= 1'b0;
                rst_cnt_reg   <= 8'h0;
                state_reg     <= SQ_RESET;
              end
              fsc_pkg::CMD_ERCHK: begin
                wr_reg    <= 1'b0;
                bus.req   <= 1'b1;
                state_reg <= SQ_ERCHK;
              end
              default: status_reg[fsc_pkg::ST_BUSY] <= 1'b0;
            endcase
          end
        end
        SQ_CYCLE: if (bus.ack) begin
          rdata_reg <= bus.rdata;
          status_reg[fsc_pkg::ST_BUSY] <= 1'b0;
          status_reg[fsc_pkg::ST_DONE] <= 1'b1;
          state_reg <= SQ_IDLE;
        end
        SQ_ERCHK: if (bus.ack) begin
          // window closed on the check after a sector command: maybe not taken
          status_reg[fsc_pkg::ST_NOTACC] <= bus.rdata[fsc_pkg::FL_ERWINDOW];
          rdata_reg <= bus.rdata;
          status_reg[fsc_pkg::ST_BUSY] <= 1'b0;
          status_reg[fsc_pkg::ST_DONE] <= 1'b1;
          state_reg <= SQ_IDLE;
        end
        SQ_POLL2: if (bus.ack) begin
          // two back-to-back status reads, compare toggle bit
          first_reg <= bus.rdata;
          bus.req   <= 1'b1;
          state_reg <= SQ_POLL3;
        end
        SQ_POLL3: if (bus.ack) begin
          if (first_reg[fsc_pkg::FL_OP_TOGGLE] == bus.rdata[fsc_pkg::FL_OP_TOGGLE]) begin
            rdata_reg <= bus.rdata;
            status_reg[fsc_pkg::ST_BUSY] <= 1'b0;
            status_reg[fsc_pkg::ST_DONE] <= 1'b1;
            state_reg <= SQ_IDLE;
          end else if (bus.rdata[fsc_pkg::FL_TIMEOUT] && after_reset_reg) begin
            // still toggling after timeout recheck: fail and reset
            status_reg[fsc_pkg::ST_FAIL] <= 1'b1;
            flash_reset_n <= 1'b0;
            rst_cnt_reg   <= 8'h0;
            state_reg     <= SQ_RESET;
          end else begin
            after_reset_reg <= bus.rdata[fsc_pkg::FL_TIMEOUT];
            first_reg <= bus.rdata;
            bus.req   <= 1'b1;
          end
        end
        SQ_RESET: begin
          rst_cnt_reg <= rst_cnt_reg + 8'h1;
          if (rst_cnt_reg == 8'(fsc_pkg::T_RESET_CYC)) begin
            flash_reset_n <= 1'b1;
            status_reg[fsc_pkg::ST_RSTDONE] <= 1'b1;
            status_reg[fsc_pkg::ST_BUSY] <= 1'b0;
            status_reg[fsc_pkg::ST_DONE] <= 1'b1;
            state_reg <= SQ_IDLE;
          end
        end
        default: state_reg <= SQ_IDLE;
      endcase
    end
  end
endmodule

/* test/fsc_top_chk.sv */
// checker: port assertions for the flash status controller
`timescale 1ns/1ps
module fsc_top_chk (
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // flash pins
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        flash_reset_n,
  input wire logic        byte_word_sel,
  input wire logic        dq_oe_n,
  input wire logic        top_data_or_low_addr_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence s_strobe;
    !ce_n [*8] ##1 ce_n [*6];
  endsequence
  sequence s_rst_low;
    !flash_reset_n [*7];
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_err_unmapped: assert property (psel && penable && pready && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (psel && penable && pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access with error");
  a_write_gate: assert property (!we_n |-> !ce_n && oe_n)
    else $error("write strobe without ce low and oe high");
  a_read_float: assert property (!oe_n |-> dq_oe_n)
    else $error("data driven during read");
  a_strobe_len: assert property ($fell(ce_n) |-> s_strobe)
    else $error("strobe phase length wrong");
  a_rst_pulse: assert property ($fell(flash_reset_n) |-> s_rst_low ##[1:30] flash_reset_n)
    else $error("reset pulse length wrong");
  a_byte_line: assert property (!byte_word_sel && !ce_n |-> !top_data_or_low_addr_oe_n)
    else $error("low address bit not driven in byte mode");
  a_cfg_byte: assert property (psel && penable && pready && pwrite && paddr == 8'h14 && !pwdata[0]
    |-> ##[1:2] !byte_word_sel)
    else $error("byte mode not selected");
  a_cfg_word: assert property (psel && penable && pready && pwrite && paddr == 8'h14 && pwdata[0]
    |-> ##[1:2] byte_word_sel)
    else $error("word mode not selected");
  a_reset_idle: assert property (disable iff (1'b0) reset |=> ce_n && we_n && flash_reset_n)
    else $error("strobes active after reset");
endmodule
bind fsc_top fsc_top_chk chk_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
  .flash_reset_n(flash_reset_n), .byte_word_sel(byte_word_sel), .dq_oe_n(dq_oe_n),
  .top_data_or_low_addr_oe_n(top_data_or_low_addr_oe_n));

/* test/fsc_flash_model.sv */
// partner: behavioural nor flash with status flags
`timescale 1ns/1ps
module fsc_flash_model (
  // strobes
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        flash_reset_n,
  input  wire logic        byte_word_sel,
  // address and data
  input  wire logic [18:0] fl_addr,
  input  wire logic [15:0] dq_o,
  input  wire logic        top_data_or_low_addr_o,
  output logic      [15:0] dq_i,
  // status pin
  output logic             ready_busy_n_in
);
  logic [7:0]  prev_cmd  = 8'h00;
  logic [18:0] prog_addr = 19'h7ffff;
  logic [15:0] prog_data = 16'hffff;
  logic [15:0] last      = 16'h0000;
  logic [15:0] rd_val;
  logic        busy      = 1'b0;
  logic        stuck     = 1'b0;
  logic        tog       = 1'b0;
  logic        tmo       = 1'b0;
  logic        poll_bit  = 1'b0;
  logic        erasing   = 1'b0;
  logic        win       = 1'b0;
  logic        etog      = 1'b0;
  logic        ers       = 1'b0;
  int          nwr       = 0;
  int          left      = 0;
  // ---------------------------------------------------------------
  // command writes
  // ---------------------------------------------------------------
  always @(posedge we_n) begin
    if (!ce_n && oe_n && flash_reset_n && (!busy || (erasing && !win))) begin
      if (erasing) begin
        if (dq_o[7:0] == 8'h30) left = left + 2;
      end else begin
        nwr = nwr + 1;
        if (nwr == 3) ers = dq_o[7:0] == 8'h80;
        if (nwr == 4 && prev_cmd == 8'ha0) begin
          stuck = fl_addr == prog_addr && prog_data != 16'hffff;
          poll_bit = ~dq_o[7];
          busy = 1'b1;
          left = 5;
          if (!stuck) begin
            prog_addr = fl_addr;
            prog_data = {top_data_or_low_addr_o, dq_o[14:0]};
          end
        end
        if (nwr == 6 && ers && dq_o[7:0] == 8'h30) begin
          busy = 1'b1;
          erasing = 1'b1;
          win = 1'b0;
          left = 4;
        end
        prev_cmd = dq_o[7:0];
        if ((nwr == 4 && !ers) || nwr == 6 || dq_o[7:0] == 8'hf0) begin
          nwr = 0;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // read ends advance the operation
  // ---------------------------------------------------------------
  always @(posedge oe_n) begin
    if (we_n) begin
      last = rd_val;
      if (busy) begin
        tog = ~tog;
        left = left - 1;
        if (erasing) begin
          etog = ~etog;
          win = 1'b1;
        end
        if (left <= 0 && stuck) begin
          tmo = 1'b1;
        end
        if (left <= 0 && !stuck) begin
          busy = 1'b0;
          erasing = 1'b0;
        end
      end
    end
  end
  always @(negedge flash_reset_n) begin
    busy = 1'b0;
    erasing = 1'b0;
    stuck = 1'b0;
    tmo = 1'b0;
    nwr = 0;
  end
  assign rd_val = busy ? (erasing ? {8'h00, 1'b0, tog, tmo, 1'b0, win, etog, 2'b00}
                                  : {8'h00, poll_bit, tog, tmo, 2'b00, 1'b1, 2'b00})
                       : (fl_addr == prog_addr ? prog_data : 16'hffff);
  assign dq_i = (!ce_n && !oe_n) ? {byte_word_sel ? rd_val[15:8] : ~last[15:8], rd_val[7:0]} : ~last;
  assign ready_busy_n_in = !busy && flash_reset_n;
endmodule

/* test/testbench.sv */
// testbench: apb-driven checks of the flash status controller
`timescale 1ns/1ps
module testbench;
  localparam logic [19:0] PA = 20'h00123;
  logic        mclk, reset, psel, penable, pwrite, pready, pslverr, e, et;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        ce_n, oe_n, we_n, flash_reset_n, byte_word_sel, dq_oe_n, top_o, top_oe_n, rb_n;
  logic [18:0] fl_addr;
  logic [15:0] dq_o, dq_i;
  int          fail_count = 0;
  int          checks     = 0;
  int          cycles     = 0;
  fsc_top dut_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .flash_reset_n(flash_reset_n), .byte_word_sel(byte_word_sel), .fl_addr(fl_addr), .dq_o(dq_o),
    .dq_oe_n(dq_oe_n), .top_data_or_low_addr_o(top_o), .top_data_or_low_addr_oe_n(top_oe_n), .dq_i(dq_i),
    .ready_busy_n_in(rb_n));
  fsc_flash_model model_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .flash_reset_n(flash_reset_n),
    .byte_word_sel(byte_word_sel), .fl_addr(fl_addr), .dq_o(dq_o), .top_data_or_low_addr_o(top_o),
    .dq_i(dq_i), .ready_busy_n_in(rb_n));
  // ---------------------------------------------------------------
  // clock, timeout, report
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic x, input logic g);
    chk_word(n, {31'h0, x}, {31'h0, g});
  endtask
  // ---------------------------------------------------------------
  // apb master and command tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [2:0] c);
    apb(1'b1, fsc_pkg::OFS_CTRL, {29'h0, c});
    do begin
      apb(1'b0, fsc_pkg::OFS_STATUS, 32'h0);
    end while (q[fsc_pkg::ST_BUSY] !== 1'b0);
  endtask
  task automatic cyc(input logic [19:0] a, input logic [15:0] d);
    apb(1'b1, fsc_pkg::OFS_ADDR, {12'h000, a});
    apb(1'b1, fsc_pkg::OFS_WDATA, {16'h0000, d});
    run(fsc_pkg::CMD_WRITE);
  endtask
  task automatic prog(input logic [15:0] d);
    cyc(20'h00555, 16'h12aa);
    cyc(20'h002aa, 16'h3455);
    cyc(20'h00555, 16'h56a0);
    cyc(PA, d);
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    apb(1'b0, fsc_pkg::OFS_CFG, 32'h0);
    chk_word("cfg", fsc_pkg::CFG_RESET, q);
    apb(1'b0, 8'h18, 32'h0);
    chk_pin("slverr", 1'b1, e);
    run(fsc_pkg::CMD_RESET);
    chk_pin("reset done", 1'b1, q[fsc_pkg::ST_RSTDONE]);
    apb(1'b0, fsc_pkg::OFS_STATUS, 32'h0);
    chk_pin("pin ready", 1'b1, q[fsc_pkg::ST_RDY]);
    $display("test reset ended");
    prog(16'h8421);
    apb(1'b0, fsc_pkg::OFS_STATUS, 32'h0);
    chk_pin("pin busy", 1'b0, q[fsc_pkg::ST_RDY]);
    run(fsc_pkg::CMD_POLL);
    chk_pin("fail", 1'b0, q[fsc_pkg::ST_FAIL]);
    chk_pin("done", 1'b1, q[fsc_pkg::ST_DONE]);
    chk_pin("no reset", 1'b0, q[fsc_pkg::ST_RSTDONE]);
    chk_pin("pin ready", 1'b1, q[fsc_pkg::ST_RDY]);
    apb(1'b1, fsc_pkg::OFS_ADDR, {12'h000, PA});
    run(fsc_pkg::CMD_READ);
    apb(1'b0, fsc_pkg::OFS_RDATA, 32'h0);
    chk_word("array", 32'h8421, {16'h0, q[15:0]});
    $display("test program ended");
    prog(16'h0001);
    run(fsc_pkg::CMD_POLL);
    chk_pin("fail", 1'b1, q[fsc_pkg::ST_FAIL]);
    chk_pin("reset done", 1'b1, q[fsc_pkg::ST_RSTDONE]);
    apb(1'b0, fsc_pkg::OFS_STATUS, 32'h0);
    chk_pin("pin ready", 1'b1, q[fsc_pkg::ST_RDY]);
    run(fsc_pkg::CMD_READ);
    apb(1'b0, fsc_pkg::OFS_RDATA, 32'h0);
    chk_word("array kept", 32'h8421, {16'h0, q[15:0]});
    $display("test timeout ended");
    cyc(20'h00555, 16'h00aa);
    cyc(20'h002aa, 16'h0055);
    cyc(20'h00555, 16'h0080);
    cyc(20'h00555, 16'h00aa);
    cyc(20'h002aa, 16'h0055);
    cyc(PA, 16'h0030);
    run(fsc_pkg::CMD_ERCHK);
    chk_pin("window open", 1'b0, q[fsc_pkg::ST_NOTACC]);
    apb(1'b0, fsc_pkg::OFS_RDATA, 32'h0);
    chk_pin("erase poll", 1'b0, q[7]);
    et = q[2];
    cyc(PA, 16'h0030);
    run(fsc_pkg::CMD_ERCHK);
    chk_pin("window closed", 1'b1, q[fsc_pkg::ST_NOTACC]);
    apb(1'b0, fsc_pkg::OFS_RDATA, 32'h0);
    chk_pin("erase toggle", ~et, q[2]);
    run(fsc_pkg::CMD_POLL);
    chk_pin("erase done", 1'b1, q[fsc_pkg::ST_DONE]);
    chk_pin("erase fail", 1'b0, q[fsc_pkg::ST_FAIL]);
    $display("test erase ended");
    apb(1'b1, fsc_pkg::OFS_CFG, 32'h0);
    apb(1'b0, fsc_pkg::OFS_CFG, 32'h0);
    chk_word("cfg byte", 32'h0, q);
    apb(1'b1, fsc_pkg::OFS_ADDR, 32'h00007);
    run(fsc_pkg::CMD_READ);
    chk_pin("width pin", 1'b0, byte_word_sel);
    apb(1'b0, fsc_pkg::OFS_RDATA, 32'h0);
    chk_word("byte data", 32'hff, {24'h0, q[7:0]});
    apb(1'b1, fsc_pkg::OFS_CFG, 32'h1);
    $display("test byte mode ended");
    complete_run();
  end
endmodule
